// ==== hw/crc_bank.sv ====
/*
 * Cable reflectometry configuration bank with run sequencer.
 * Assumes an Avalon-MM master honouring waitrequest, and an engine that
 * pulses cycle_done once per averaged cycle with peak_pos valid on the last.
 */
// Decided for this implementation: the Avalon-MM register port.
// Functional notes
// - Bit 14 clear senses the other pair; set senses the transmit pair.
// - Bit 13 selects the pulse pair, zero pair A, one pair B.
// - Bit 12 keeps DC removal from reinitialising before a run.
// - Bits 10-8 choose 1 to 64 averaged cycles; code 7 reserved; reset 4.
// - Bits 6-4 choose cable segment; codes 0, 6 and 7 are reserved.
// - Bits 15-8 hold segment sample window, metres times 2 times 5.2 over 8.
// - Bits 7-0 give samples discarded before the segment window.
// - After a run, first peak position on transmit pair is readable.
module crc_bank
   import crc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire crc_avs_req_s avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cycle_done,
   input wire logic [7:0] peak_pos,
   output logic run_start,
   output crc_cfg_s tdr_cfg
);

   // Decode three-bit average code into a cycle count; the reserved code yields zero
   function automatic logic [6:0] avg_count(input logic [2:0] code);
      unique case (code)
         3'h0: avg_count = 7'h01;
         3'h1: avg_count = 7'h02;
         3'h2: avg_count = 7'h04;
         3'h3: avg_count = 7'h08;
         3'h4: avg_count = 7'h10;
         3'h5: avg_count = 7'h20;
         3'h6: avg_count = 7'h40;
         default: avg_count = 7'h00;
      endcase
   endfunction : avg_count

   // Word index from a byte address; the two low bits are checked apart
   function automatic logic [8:0] word_idx(input logic [10:0] addr);
      word_idx = addr[10:2];
   endfunction : word_idx

   logic [15:0] control_ff, nxt_control;
   logic [15:0] window_ff, nxt_window;
   logic [7:0] peak_ff, nxt_peak;
   logic done_ff, nxt_done;
   logic err_ff, nxt_err;
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   crc_state_e state_ff, nxt_state;
   logic [6:0] cnt_ff, nxt_cnt;
   logic start_ff, nxt_start;
   crc_cfg_s cfg_ff, nxt_cfg;

   logic [8:0] idx;
   logic aligned;
   logic wr_go;
   logic [15:0] wmask;
   logic [15:0] wval;
   logic launch;
   logic cfg_ok;
   logic [2:0] avg_code;
   logic [2:0] seg_code;

   // Access decode and write lane mask
   always_comb begin
      idx = word_idx(avs_req.address);
      aligned = (avs_req.address[1:0] == 2'h0);
      wr_go = avs_req.write && !wait_ff && aligned;
      wmask = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
      wval = avs_req.writedata[15:0];
      avg_code = control_ff[CTL_AVG_LSB +: 3];
      seg_code = control_ff[CTL_SEG_LSB +: 3];
      cfg_ok = (avg_code != AVG_RSVD) && (seg_code >= SEG_FIRST) && (seg_code <= SEG_LAST);
      // A start is taken only when idle; a start while busy is dropped
      launch = wr_go && (idx == IDX_RUN) && avs_req.byteenable[0] && wval[RUN_START]
               && (state_ff == CRC_IDLE);
   end

   // Bus handshake: one wait cycle, then answer
   always_comb begin
      nxt_wait = !((avs_req.read || avs_req.write) && wait_ff);
      nxt_rdata = rdata_ff;
      if ((avs_req.read) && wait_ff) begin
         // Unmapped or misaligned reads return zero
         nxt_rdata = 32'h00000000;
         if (aligned) begin
            unique case (idx)
               IDX_CONTROL: nxt_rdata = {16'h0000, control_ff};
               IDX_SEG_WINDOW: nxt_rdata = {16'h0000, window_ff};
               IDX_RUN: nxt_rdata = {28'h0000000, err_ff, done_ff, (state_ff == CRC_RUN), 1'b0};
               IDX_FIRST_PEAK: nxt_rdata = {24'h000000, peak_ff};
               default: nxt_rdata = 32'h00000000;
            endcase
         end
      end
   end

   // Configuration registers; locked while a run is in progress
   always_comb begin
      nxt_control = control_ff;
      nxt_window = window_ff;
      // Writes during a run are dropped so the snapshot stays coherent
      if (wr_go && state_ff == CRC_IDLE) begin
         if (idx == IDX_CONTROL) begin
            nxt_control = ((control_ff & ~wmask) | (wval & wmask)) & CTL_RW_MASK;
         end
         if (idx == IDX_SEG_WINDOW) begin
            nxt_window = (window_ff & ~wmask) | (wval & wmask);
         end
      end
   end

   // Run sequencer: latch config, count averaged cycles, capture peak
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_start = 1'b0;
      nxt_cfg = cfg_ff;
      nxt_peak = peak_ff;
      nxt_done = done_ff;
      nxt_err = err_ff;
      // Software clears flags by writing one; hardware set wins below
      if (wr_go && idx == IDX_RUN && avs_req.byteenable[0]) begin
         if (wval[RUN_DONE]) begin
            nxt_done = 1'b0;
         end
         if (wval[RUN_ERR]) begin
            nxt_err = 1'b0;
         end
      end
      unique case (state_ff)
         CRC_IDLE: begin
            if (launch && !cfg_ok) begin
               nxt_err = 1'b1; // Reserved code refuses the run
            end else if (launch) begin
               // Snapshot every field so later edits cannot reach the engine
               nxt_cfg.sense_pair_b = control_ff[CTL_CROSS_DIS] ~^ control_ff[CTL_CHAN_SEL];
               nxt_cfg.tx_pair_b = control_ff[CTL_CHAN_SEL];
               nxt_cfg.keep_dc_removal_state = control_ff[CTL_DC_KEEP];
               nxt_cfg.avg_cycles = avg_count(avg_code);
               nxt_cfg.segment = seg_code;
               nxt_cfg.seg_duration = window_ff[WIN_DUR_LSB +: 8];
               nxt_cfg.initial_skip = window_ff[WIN_SKIP_LSB +: 8];
               nxt_cnt = 7'h00;
               nxt_start = 1'b1;
               nxt_done = 1'b0;
               nxt_state = CRC_RUN;
            end
         end
         CRC_RUN: begin
            if (cycle_done) begin
               // Count guard ends the run on the 128th pulse should the count never match avg_cycles
               if (cnt_ff + 7'h01 == cfg_ff.avg_cycles || cnt_ff == 7'h7F) begin
                  nxt_peak = peak_pos;
                  nxt_done = 1'b1;
                  nxt_state = CRC_IDLE;
               end else begin
                  nxt_cnt = cnt_ff + 7'h01;
               end
            end
         end
      endcase
   end

   // Bus handshake registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
      end else begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control_ff <= RST_CONTROL;
         window_ff <= RST_SEG_WINDOW;
      end else begin
         control_ff <= nxt_control;
         window_ff <= nxt_window;
      end
   end

   // Run sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         peak_ff <= 8'h00;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         state_ff <= CRC_IDLE;
         cnt_ff <= 7'h00;
         start_ff <= 1'b0;
         cfg_ff <= '0;
      end else begin
         peak_ff <= nxt_peak;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         start_ff <= nxt_start;
         cfg_ff <= nxt_cfg;
      end
   end

   // Outputs straight from flops
   always_comb begin
      avs_readdata = rdata_ff;
      avs_waitrequest = wait_ff;
      run_start = start_ff;
      tdr_cfg = cfg_ff;
   end

endmodule : crc_bank

// ==== hw/crc_pkg.sv ====
/*
 * Constants, field layouts and carrier types of the cable reflectometry
 * configuration bank. Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package crc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [8:0] IDX_CONTROL = 9'h170;
   localparam logic [8:0] IDX_SPARE_A = 9'h171;
   localparam logic [8:0] IDX_SPARE_B = 9'h172;
   localparam logic [8:0] IDX_SEG_WINDOW = 9'h173;
   localparam logic [8:0] IDX_SPARE_C = 9'h174;
   localparam logic [8:0] IDX_RUN = 9'h17F;
   localparam logic [8:0] IDX_FIRST_PEAK = 9'h180;

   // Reset values
   localparam logic [15:0] RST_CONTROL = 16'h0410;
   localparam logic [15:0] RST_SEG_WINDOW = 16'h0D04;

   // Control register field positions
   localparam int CTL_CROSS_DIS = 14;
   localparam int CTL_CHAN_SEL = 13;
   localparam int CTL_DC_KEEP = 12;
   localparam int CTL_AVG_LSB = 8;
   localparam int CTL_SEG_LSB = 4;
   // Writable bits of the control register
   localparam logic [15:0] CTL_RW_MASK = 16'h7770;

   // Segment window field positions
   localparam int WIN_DUR_LSB = 8;
   localparam int WIN_SKIP_LSB = 0;

   // Run register bits
   localparam int RUN_START = 0;
   localparam int RUN_BUSY = 1;
   localparam int RUN_DONE = 2;
   localparam int RUN_ERR = 3;

   // Reserved average code and legal segment code range
   localparam logic [2:0] AVG_RSVD = 3'h7;
   localparam logic [2:0] SEG_FIRST = 3'h1;
   localparam logic [2:0] SEG_LAST = 3'h5;

   // Run sequencer states
   typedef enum logic [0:0] {
      CRC_IDLE = 1'b0,
      CRC_RUN = 1'b1
   } crc_state_e;

   // Configuration held stable toward the reflectometry engine
   typedef struct packed {
      logic tx_pair_b;
      logic sense_pair_b;
      logic keep_dc_removal_state;
      logic [6:0] avg_cycles;
      logic [2:0] segment;
      logic [7:0] seg_duration;
      logic [7:0] initial_skip;
   } crc_cfg_s;

   // Avalon-MM slave request
   typedef struct packed {
      logic [10:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } crc_avs_req_s;
endpackage : crc_pkg

// ==== verif/crc_bank_properties.sv ====
/* Port checker for crc_bank.
   Assumes the bind below. */
module crc_bank_properties
   import crc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire crc_avs_req_s avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic cycle_done,
   input wire logic [7:0] peak_pos,
   input wire logic run_start,
   input wire crc_cfg_s tdr_cfg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Pending request and accepted start write
   logic req;
   logic start_wr;
   assign req = avs_req.read | avs_req.write;
   assign start_wr = avs_req.write & !avs_waitrequest & avs_req.writedata[0] & (avs_req.address[10:2] == IDX_RUN);
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   chk_one_wait: assert property (req && avs_waitrequest |=> s_answer) else $error("bus answer not in one cycle");
   chk_no_spurious: assert property (!avs_waitrequest |-> $past(req)) else $error("answer without request");
   chk_start_cause: assert property (run_start |-> $past(start_wr)) else $error("launch without start");
   chk_start_pulse: assert property (run_start |=> !run_start) else $error("launch pulse too long");
   chk_cfg_hold: assert property (!run_start |-> $stable(tdr_cfg)) else $error("config moved");
   chk_avg_pow2: assert property (run_start |-> $onehot(tdr_cfg.avg_cycles)) else $error("bad count");
   chk_seg_legal: assert property (run_start |-> tdr_cfg.segment inside {[1:5]}) else $error("bad span");
   chk_upper_zero: assert property (avs_readdata[31:16] == 16'h0) else $error("upper read bits set");
   chk_rdata_stands: assert property (avs_waitrequest |-> $stable(avs_readdata)) else $error("read data moved");
endmodule : crc_bank_properties

bind crc_bank crc_bank_properties crc_bank_properties_i (.clk, .rst_n, .avs_req, .avs_readdata,
   .avs_waitrequest, .cycle_done, .peak_pos, .run_start, .tdr_cfg);

// ==== verif/crc_engine_model.sv ====
/* Cable-side engine stand-in.
   Assumes run_start pulses once per launch. */
module crc_engine_model
   import crc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run_start,
   input wire crc_cfg_s tdr_cfg,
   output logic cycle_done,
   output logic [7:0] peak_pos
);
   int left;
   int gap;
   // One pulse per averaged cycle, spacing varies; peak only on the last
   always @(posedge clk or negedge rst_n) begin
      cycle_done <= 1'b0;
      peak_pos <= ~peak_pos;
      if (!rst_n) begin
         left <= 0;
         peak_pos <= 8'h0;
      end else if (run_start) begin
         left <= int'(tdr_cfg.avg_cycles);
         gap <= 6 + tdr_cfg.initial_skip[1:0];
      end else if (left > 0 && gap > 0) begin
         gap <= gap - 1;
      end else if (left > 0) begin
         cycle_done <= 1'b1;
         left <= left - 1;
         gap <= 6 + tdr_cfg.initial_skip[1:0];
         if (left == 1) peak_pos <= tdr_cfg.initial_skip ^ tdr_cfg.seg_duration;
      end
   end
endmodule : crc_engine_model

// ==== verif/testbench.sv ====
/* Self-checking bench for crc_bank.
   Assumes crc_engine_model as far side. */
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench
   import crc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   crc_avs_req_s req = '0;
   logic [31:0] rdata;
   logic wt, cd, rs, rd_on = 1'b0;
   logic [7:0] pk;
   crc_cfg_s cfg, y;
   logic [31:0] rq[$];
   crc_cfg_s cq[$];
   int err_total = 0, checked = 0, cyc = 0;
   logic [31:0] v, x;
   logic [15:0] cw;
   logic [2:0] a;
   logic [1:0] p;
   logic [8:0] ri[7] = '{9'h170, 9'h171, 9'h172, 9'h173, 9'h174, 9'h180, 9'h1FF};
   logic [15:0] rv[7] = '{16'h0410, 16'h0, 16'h0, 16'h0D04, 16'h0, 16'h0, 16'h0};
   logic [15:0] bad[4] = '{16'h0770, 16'h0000, 16'h0060, 16'h0710};
   logic [7:0] dur[5] = '{8'h0D, 8'h0D, 8'h1A, 8'h34, 8'h8F};
   logic [7:0] skp[5] = '{8'h07, 8'h14, 8'h21, 8'h3B, 8'h6F};
   always #12.5 clk = ~clk;
   crc_bank crc_bank_i (.clk, .rst_n, .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wt),
      .cycle_done(cd), .peak_pos(pk), .run_start(rs), .tdr_cfg(cfg));
   crc_engine_model crc_engine_model_i (.clk, .rst_n, .run_start(rs), .tdr_cfg(cfg), .cycle_done(cd), .peak_pos(pk));
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // One access held until waitrequest low; reads are checked when a note waits
   task automatic bus(input logic we, input logic [8:0] idx, input logic [31:0] d);
      req <= '{address: {idx, 2'h0}, read: !we, write: we, writedata: d, byteenable: 4'hF};
      rd_on <= !we && rq.size() > 0;
      do @(posedge clk); while (wt !== 1'b0);
      v = rdata;
      req <= '0;
      rd_on <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rc(input logic [8:0] idx, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask : rc
   // Compare results with the oldest notes; cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (rd_on && wt === 1'b0) begin
         x = rq.pop_front();
         `CHK("readdata", x, rdata)
      end
      if (rs === 1'b1) begin
         y = cq.pop_front();
         `CHK("tdr_cfg", y, cfg)
      end
      if (cyc > 40000) begin
         err_total++;
         tally_and_finish();
      end
   end
   // Reset values, reserved codes, then one run per segment
   initial begin
      void'($urandom(53));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (ri[i]) rc(ri[i], {16'h0, rv[i]});
      bus(1'b1, IDX_CONTROL, 32'hFFFFFFFF);
      rc(IDX_CONTROL, 32'h7770);
      foreach (bad[i]) begin
         bus(1'b1, IDX_RUN, 32'h8);
         bus(1'b1, IDX_CONTROL, {16'h0, bad[i]});
         bus(1'b1, IDX_RUN, 32'h1);
         bus(1'b0, IDX_RUN, 32'h0);
         `CHK("refused", 1'b1, v[RUN_ERR])
      end
      for (int k = 0; k < 5; k++) begin
         a = 3'($urandom_range(6));
         p = 2'($urandom);
         cw = {1'b0, p, 1'(k), 1'b0, a, 1'b0, 3'(k + 1), 4'h0};
         cq.push_back({p[0], p[1] ? p[0] : ~p[0], 1'(k), 7'(1 << a), 3'(k + 1), dur[k], skp[k]});
         bus(1'b1, IDX_CONTROL, {16'h0, cw});
         bus(1'b1, IDX_SEG_WINDOW, {16'h0, dur[k], skp[k]});
         bus(1'b1, IDX_RUN, 32'h1);
         bus(1'b1, IDX_CONTROL, 32'h0);
         do bus(1'b0, IDX_RUN, 32'h0); while (v[RUN_BUSY] === 1'b1);
         `CHK("done", 1'b1, v[RUN_DONE])
         rc(IDX_FIRST_PEAK, {24'h0, dur[k] ^ skp[k]});
         rc(IDX_CONTROL, {16'h0, cw});
         rc(IDX_SEG_WINDOW, {16'h0, dur[k], skp[k]});
         bus(1'b1, IDX_RUN, 32'hC);
         rc(IDX_RUN, 32'h0);
      end
      tally_and_finish();
   end
endmodule : testbench
